// ==== rsa_pkg.sv ====
package rsa_pkg;

  localparam int RSA_DW = 8;

  // Operation codes presented by the sequencer
  typedef enum logic [4:0] {
    RSA_OP_ROTL_CARRY_TO_ACCUM = 5'h00,
    RSA_OP_ROTATE_RIGHT_MEM = 5'h01,
    RSA_OP_ROTATE_RIGHT_TO_ACCUM = 5'h02,
    RSA_OP_ROTATE_RIGHT_CARRY_MEM = 5'h03,
    RSA_OP_ROTATE_RIGHT_CARRY_TO_ACCUM = 5'h04,
    RSA_OP_MINUS_BORROW_TO_ACCUM = 5'h05,
    RSA_OP_MINUS_BORROW_IMM = 5'h06,
    RSA_OP_MINUS_BORROW_TO_MEM = 5'h07,
    RSA_OP_MINUS_TO_ACCUM = 5'h08,
    RSA_OP_MINUS_IMM = 5'h09,
    RSA_OP_MINUS_TO_MEM = 5'h0A,
    RSA_OP_DEC_SKIP_ZERO = 5'h0B,
    RSA_OP_DEC_SKIP_ZERO_ACCUM = 5'h0C,
    RSA_OP_INC_SKIP_ZERO = 5'h0D,
    RSA_OP_INC_SKIP_ZERO_ACCUM = 5'h0E,
    RSA_OP_FILL_ONES = 5'h0F,
    RSA_OP_BIT_SET = 5'h10,
    RSA_OP_SKIP_BIT_NONZERO = 5'h11,
    RSA_OP_SKIP_NONZERO = 5'h12,
    RSA_OP_SKIP_ON_ZERO = 5'h13,
    RSA_OP_NIBBLE_EXCHANGE_MEM = 5'h14,
    RSA_OP_NIBBLE_EXCHANGE_TO_ACCUM = 5'h15
  } rsa_op_t;

  typedef enum logic [1:0] {
    RSA_IDLE = 2'b00,
    RSA_EXEC = 2'b01,
    RSA_DUMMY = 2'b11
  } rsa_state_t;

  typedef enum logic [1:0] {
    RSA_ROT_L_CARRY = 2'h0,
    RSA_ROT_R = 2'h1,
    RSA_ROT_R_CARRY = 2'h2,
    RSA_ROT_SWAP = 2'h3
  } rsa_rot_t;

  // Register map
  localparam logic [1:0] RSA_REG_ACC = 2'h0;
  localparam logic [1:0] RSA_REG_STATUS = 2'h1;
  localparam logic [1:0] RSA_REG_STATE = 2'h2;

  // Status field positions
  localparam int RSA_ST_CARRY = 0;
  localparam int RSA_ST_HALF = 1;
  localparam int RSA_ST_ZERO = 2;
  localparam int RSA_ST_OVF = 3;
  localparam int RSA_ST_SIGNED = 4;
  localparam int RSA_ST_CHAIN = 5;
  localparam int RSA_ST_W = 6;

  localparam logic [7:0] RSA_ACC_RST = 8'h00;
  localparam logic [5:0] RSA_STATUS_RST = 6'h00;
  localparam logic [7:0] RSA_ALL_ONES = 8'hFF;
  localparam logic [7:0] RSA_ONE = 8'h01;

  // Nine-bit difference; bit 8 set means a borrow out
  function automatic logic [8:0] rsa_sub9(input logic [7:0] a, input logic [7:0] b, input logic bw);
    rsa_sub9 = {1'b0, a} - {1'b0, b} - {8'h00, bw};
  endfunction

endpackage

// ==== rsa_alu_if.sv ====
`timescale 1ns/1ps
interface rsa_alu_if;
  logic [7:0] acc;
  logic [7:0] opnd;
  logic cin;
  logic czin;
  logic use_borrow;
  rsa_pkg::rsa_rot_t rot_sel;
  logic [7:0] rot_res;
  logic rot_cout;
  logic [7:0] sub_res;
  logic [5:0] sub_flags;
  modport core(output acc, opnd, cin, czin, use_borrow, rot_sel,
               input rot_res, rot_cout, sub_res, sub_flags);
  modport rot(input opnd, cin, rot_sel, output rot_res, rot_cout);
  modport sub(input acc, opnd, cin, czin, use_borrow, output sub_res, sub_flags);
endinterface

// ==== rsa_rotate.sv ====
`timescale 1ns/1ps
module rsa_rotate (
  rsa_alu_if.rot alu // Operand in, rotated byte out
);
  import rsa_pkg::*;

  always_comb begin
    alu.rot_res = alu.opnd;
    alu.rot_cout = alu.cin;
    unique case (alu.rot_sel)
      RSA_ROT_L_CARRY: begin
        alu.rot_res = {alu.opnd[6:0], alu.cin};
        alu.rot_cout = alu.opnd[7];
      end
      RSA_ROT_R: begin
        alu.rot_res = {alu.opnd[0], alu.opnd[7:1]};
      end
      RSA_ROT_R_CARRY: begin
        alu.rot_res = {alu.cin, alu.opnd[7:1]};
        alu.rot_cout = alu.opnd[0];
      end
      RSA_ROT_SWAP: begin
        alu.rot_res = {alu.opnd[3:0], alu.opnd[7:4]};
      end
    endcase
  end

endmodule

// ==== rsa_subtract.sv ====
`timescale 1ns/1ps
module rsa_subtract (
  rsa_alu_if.sub alu // Minuend, subtrahend, flags out
);
  import rsa_pkg::*;

  logic bw;
  logic [8:0] full;
  logic [8:0] half;
  logic ovf;
  logic zero;

  always_comb begin
    bw = alu.use_borrow & ~alu.cin;
    full = rsa_sub9(alu.acc, alu.opnd, bw);
    half = rsa_sub9({4'h0, alu.acc[3:0]}, {4'h0, alu.opnd[3:0]}, bw);
    alu.sub_res = full[7:0];
    zero = (full[7:0] == 8'h00);
    ovf = (alu.acc[7] ^ alu.opnd[7]) & (alu.acc[7] ^ full[7]);
    alu.sub_flags[RSA_ST_CARRY] = ~full[8];
    alu.sub_flags[RSA_ST_HALF] = ~half[8];
    alu.sub_flags[RSA_ST_ZERO] = zero;
    alu.sub_flags[RSA_ST_OVF] = ovf;
    alu.sub_flags[RSA_ST_SIGNED] = full[7] ^ ovf;
    // Chained zero only holds across a borrow chain
    alu.sub_flags[RSA_ST_CHAIN] = alu.use_borrow ? (zero & alu.czin) : zero;
  end

endmodule

// ==== rsa_core.sv ====
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module rsa_core (
  input wire logic sys_clk, // System clock
  input wire logic nrst, // Synchronous reset, active low
  input wire logic clk_en, // Freezes all state while low
  input wire logic op_valid, // Operation offered
  input wire logic [4:0] op_code, // rsa_pkg::rsa_op_t code
  input wire logic [7:0] op_imm, // Immediate operand
  input wire logic [2:0] op_bit, // Bit select
  input wire logic [7:0] mem_rdata, // Addressed memory byte
  output logic op_ready, // Idle, operation may be offered
  output logic op_done, // Operation retired
  output logic skip_next, // Skip the following instruction
  output logic mem_wr_en, // Write memory byte
  output logic [7:0] mem_wr_data, // Byte to write
  output logic [7:0] acc_out, // Accumulator
  output logic [5:0] status_out, // Status flags
  input wire logic [1:0] reg_addr, // Register address
  input wire logic [7:0] reg_wdata, // Register write data
  input wire logic reg_wr, // Register write strobe
  input wire logic reg_rd, // Register read strobe
  output logic [7:0] reg_rdata // Read data, cycle after strobe
);
  import rsa_pkg::*;

  rsa_alu_if alu ();

  rsa_state_t state;
  rsa_state_t next_state;
  rsa_op_t op_q;
  logic op_known;
  logic [7:0] opnd_q;
  logic [7:0] imm_q;
  logic [2:0] bit_q;
  logic [7:0] acc;
  logic [5:0] status;
  logic last_skip;

  logic [7:0] inc_val;
  logic [7:0] dec_val;
  logic [7:0] bit_mask;
  logic wr_acc;
  logic [7:0] next_acc;
  logic wr_mem;
  logic [7:0] next_mem;
  logic wr_carry;
  logic wr_subflags;
  logic take_skip;

  rsa_rotate u_rotate (
    .alu(alu.rot)
  );

  rsa_subtract u_subtract (
    .alu(alu.sub)
  );

  function automatic logic is_imm(input rsa_op_t op);
    is_imm = (op == RSA_OP_MINUS_BORROW_IMM) || (op == RSA_OP_MINUS_IMM);
  endfunction

  function automatic logic is_borrow(input rsa_op_t op);
    is_borrow = (op == RSA_OP_MINUS_BORROW_TO_ACCUM) || (op == RSA_OP_MINUS_BORROW_IMM)
             || (op == RSA_OP_MINUS_BORROW_TO_MEM);
  endfunction

  // Operand routing into the shared units
  always_comb begin
    alu.acc = acc;
    alu.opnd = is_imm(op_q) ? imm_q : opnd_q;
    alu.cin = status[RSA_ST_CARRY];
    alu.czin = status[RSA_ST_CHAIN];
    alu.use_borrow = is_borrow(op_q);
    unique case (op_q)
      RSA_OP_ROTL_CARRY_TO_ACCUM: alu.rot_sel = RSA_ROT_L_CARRY;
      RSA_OP_ROTATE_RIGHT_CARRY_MEM,
      RSA_OP_ROTATE_RIGHT_CARRY_TO_ACCUM: alu.rot_sel = RSA_ROT_R_CARRY;
      RSA_OP_NIBBLE_EXCHANGE_MEM,
      RSA_OP_NIBBLE_EXCHANGE_TO_ACCUM: alu.rot_sel = RSA_ROT_SWAP;
      default: alu.rot_sel = RSA_ROT_R;
    endcase
  end

  // Eight-bit wrap is intended
  assign inc_val = opnd_q + RSA_ONE;
  assign dec_val = opnd_q - RSA_ONE;
  assign bit_mask = RSA_ONE << bit_q;

  // Result and side-effect decode for the operation in flight
  always_comb begin
    wr_acc = 1'b0;
    next_acc = acc;
    wr_mem = 1'b0;
    next_mem = opnd_q;
    wr_carry = 1'b0;
    wr_subflags = 1'b0;
    take_skip = 1'b0;
    if (op_known) begin
      unique case (op_q)
        RSA_OP_ROTL_CARRY_TO_ACCUM: begin
          wr_acc = 1'b1;
          next_acc = alu.rot_res;
          wr_carry = 1'b1;
        end
        RSA_OP_ROTATE_RIGHT_MEM: begin
          wr_mem = 1'b1;
          next_mem = alu.rot_res;
        end
        RSA_OP_ROTATE_RIGHT_TO_ACCUM: begin
          wr_acc = 1'b1;
          next_acc = alu.rot_res;
        end
        RSA_OP_ROTATE_RIGHT_CARRY_MEM: begin
          wr_mem = 1'b1;
          next_mem = alu.rot_res;
          wr_carry = 1'b1;
        end
        RSA_OP_ROTATE_RIGHT_CARRY_TO_ACCUM: begin
          wr_acc = 1'b1;
          next_acc = alu.rot_res;
          wr_carry = 1'b1;
        end
        RSA_OP_MINUS_BORROW_TO_ACCUM,
        RSA_OP_MINUS_BORROW_IMM: begin
          wr_acc = 1'b1;
          next_acc = alu.sub_res;
          wr_subflags = 1'b1;
        end
        RSA_OP_MINUS_BORROW_TO_MEM: begin
          wr_mem = 1'b1;
          next_mem = alu.sub_res;
          wr_subflags = 1'b1;
        end
        RSA_OP_MINUS_TO_ACCUM,
        RSA_OP_MINUS_IMM: begin
          wr_acc = 1'b1;
          next_acc = alu.sub_res;
          wr_subflags = 1'b1;
        end
        RSA_OP_MINUS_TO_MEM: begin
          wr_mem = 1'b1;
          next_mem = alu.sub_res;
          wr_subflags = 1'b1;
        end
        RSA_OP_DEC_SKIP_ZERO: begin
          wr_mem = 1'b1;
          next_mem = dec_val;
          take_skip = (dec_val == 8'h00);
        end
        RSA_OP_DEC_SKIP_ZERO_ACCUM: begin
          wr_acc = 1'b1;
          next_acc = dec_val;
          take_skip = (dec_val == 8'h00);
        end
        RSA_OP_INC_SKIP_ZERO: begin
          wr_mem = 1'b1;
          next_mem = inc_val;
          take_skip = (inc_val == 8'h00);
        end
        RSA_OP_INC_SKIP_ZERO_ACCUM: begin
          wr_acc = 1'b1;
          next_acc = inc_val;
          take_skip = (inc_val == 8'h00);
        end
        RSA_OP_FILL_ONES: begin
          wr_mem = 1'b1;
          next_mem = RSA_ALL_ONES;
        end
        RSA_OP_BIT_SET: begin
          wr_mem = 1'b1;
          next_mem = opnd_q | bit_mask;
        end
        RSA_OP_SKIP_BIT_NONZERO: begin
          take_skip = ((opnd_q & bit_mask) != 8'h00);
        end
        RSA_OP_SKIP_NONZERO: begin
          wr_mem = 1'b1;
          take_skip = (opnd_q != 8'h00);
        end
        RSA_OP_SKIP_ON_ZERO: begin
          wr_mem = 1'b1;
          take_skip = (opnd_q == 8'h00);
        end
        RSA_OP_NIBBLE_EXCHANGE_MEM: begin
          wr_mem = 1'b1;
          next_mem = alu.rot_res;
        end
        RSA_OP_NIBBLE_EXCHANGE_TO_ACCUM: begin
          wr_acc = 1'b1;
          next_acc = alu.rot_res;
        end
      endcase
    end
  end

  // Sequencer: idle, execute, and one dummy slot after a taken skip
  always_comb begin
    next_state = state;
    unique case (state)
      RSA_IDLE: begin
        if (op_valid) begin
          next_state = RSA_EXEC;
        end
      end
      RSA_EXEC: begin
        next_state = take_skip ? RSA_DUMMY : RSA_IDLE;
      end
      RSA_DUMMY: begin
        next_state = RSA_IDLE;
      end
      default: begin
        next_state = RSA_IDLE;
      end
    endcase
  end

  assign op_ready = (state == RSA_IDLE);

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state <= RSA_IDLE;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  // Operation capture; memory byte sampled together with the code
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      op_q <= RSA_OP_ROTATE_RIGHT_MEM;
      op_known <= 1'b0;
      opnd_q <= 8'h00;
      imm_q <= 8'h00;
      bit_q <= 3'h0;
    end else if (clk_en && op_ready && op_valid) begin
      op_q <= rsa_op_t'(op_code);
      op_known <= (op_code <= RSA_OP_NIBBLE_EXCHANGE_TO_ACCUM);
      opnd_q <= mem_rdata;
      imm_q <= op_imm;
      bit_q <= op_bit;
    end
  end

  // Accumulator; the executing operation wins over a bus write
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      acc <= RSA_ACC_RST;
    end else if (clk_en) begin
      if (state == RSA_EXEC && wr_acc) begin
        acc <= next_acc;
      end else if (reg_wr && reg_addr == RSA_REG_ACC) begin
        acc <= reg_wdata;
      end
    end
  end

  // Status flags; untouched by every operation that does not name them
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      status <= RSA_STATUS_RST;
    end else if (clk_en) begin
      if (state == RSA_EXEC && wr_subflags) begin
        status <= alu.sub_flags;
      end else if (state == RSA_EXEC && wr_carry) begin
        status[RSA_ST_CARRY] <= alu.rot_cout;
      end else if (reg_wr && reg_addr == RSA_REG_STATUS) begin
        status <= reg_wdata[RSA_ST_W-1:0];
      end
    end
  end

  // Memory write-back and completion, registered
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      mem_wr_en <= 1'b0;
      mem_wr_data <= 8'h00;
      op_done <= 1'b0;
      skip_next <= 1'b0;
    end else if (clk_en) begin
      mem_wr_en <= (state == RSA_EXEC) && wr_mem;
      if (state == RSA_EXEC) begin
        mem_wr_data <= next_mem;
      end
      op_done <= (state == RSA_EXEC);
      skip_next <= (state == RSA_EXEC) && take_skip;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      last_skip <= 1'b0;
    end else if (clk_en && state == RSA_EXEC) begin
      last_skip <= take_skip;
    end
  end

  // Register read port, unmapped addresses read zero
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        unique case (reg_addr)
          RSA_REG_ACC: reg_rdata <= acc;
          RSA_REG_STATUS: reg_rdata <= {2'b00, status};
          RSA_REG_STATE: reg_rdata <= {4'h0, op_known, last_skip, state};
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  assign acc_out = acc;
  assign status_out = status;

endmodule

// ==== rsa_core_props.sv ====
`timescale 1ns/1ps
module rsa_core_props (
  input wire logic sys_clk, // System clock
  input wire logic nrst, // Synchronous reset, active low
  input wire logic clk_en, // Clock enable
  input wire logic op_valid, // Operation offered
  input wire logic [4:0] op_code, // Operation code
  input wire logic [7:0] mem_rdata, // Operand byte
  input wire logic op_ready, // Core idle
  input wire logic op_done, // Operation retired
  input wire logic skip_next, // Skip taken
  input wire logic mem_wr_en, // Memory write
  input wire logic [7:0] mem_wr_data, // Memory write byte
  input wire logic [7:0] acc_out, // Accumulator
  input wire logic [5:0] status_out // Status flags
);
  import rsa_pkg::*;
  logic take;
  logic in_exec;
  logic [4:0] c_code;
  logic [7:0] c_mem;
  logic [7:0] c_acc;
  logic [5:0] c_st;
  assign take = nrst && clk_en && op_valid && op_ready;
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      in_exec <= 1'b0;
    end else if (clk_en) begin
      in_exec <= take;
    end
  end
  // Acc and flags taken in exec, after a retiring op has landed
  always_ff @(posedge sys_clk) begin
    if (take) begin
      c_code <= op_code;
      c_mem <= mem_rdata;
    end
    if (in_exec && clk_en) begin
      c_acc <= acc_out;
      c_st <= status_out;
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  AST_DONE_LAT: assert property (take ##1 clk_en |=> op_done)
    else $error("op_done not two cycles after take");
  AST_BUSY: assert property (in_exec |-> !op_ready && !op_done)
    else $error("ready while executing");
  AST_SKIP_DUMMY: assert property (skip_next |-> op_done && !op_ready)
    else $error("skip without dummy cycle");
  AST_DUMMY_ONE: assert property (skip_next && clk_en |=> op_ready && !op_done)
    else $error("dummy cycle not exactly one");
  AST_ROTL_CARRY_ACC: assert property (op_done && c_code == RSA_OP_ROTL_CARRY_TO_ACCUM |->
    acc_out == {c_mem[6:0], c_st[0]} && status_out == {c_st[5:1], c_mem[7]} && !mem_wr_en)
    else $error("rotate left through carry wrong");
  AST_ROT_RIGHT_MEM: assert property (op_done && c_code == RSA_OP_ROTATE_RIGHT_MEM |->
    mem_wr_en && mem_wr_data == {c_mem[0], c_mem[7:1]} && status_out == c_st)
    else $error("rotate right wrong");
  AST_SUB: assert property (op_done && c_code == RSA_OP_MINUS_TO_ACCUM |->
    acc_out == 8'(c_acc - c_mem) && status_out[0] == (c_acc >= c_mem))
    else $error("subtract result or carry wrong");
  AST_DSZ: assert property (op_done && c_code == RSA_OP_DEC_SKIP_ZERO |->
    mem_wr_en && mem_wr_data == 8'(c_mem - 8'h01) && skip_next == (c_mem == 8'h01))
    else $error("decrement skip wrong");
  AST_FILL: assert property (op_done && c_code == RSA_OP_FILL_ONES |->
    mem_wr_en && mem_wr_data == 8'hFF && status_out == c_st)
    else $error("fill ones wrong");
  AST_NIBBLE_ACC: assert property (op_done && c_code == RSA_OP_NIBBLE_EXCHANGE_TO_ACCUM |->
    acc_out == {c_mem[3:0], c_mem[7:4]} && !mem_wr_en)
    else $error("nibble exchange to accumulator wrong");
  cover property (skip_next && clk_en);
  cover property (take && op_code == RSA_OP_MINUS_BORROW_TO_MEM);
  cover property (op_done && !clk_en);
endmodule

bind rsa_core rsa_core_props u_props (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en), .op_valid(op_valid),
  .op_code(op_code), .mem_rdata(mem_rdata), .op_ready(op_ready), .op_done(op_done), .skip_next(skip_next),
  .mem_wr_en(mem_wr_en), .mem_wr_data(mem_wr_data), .acc_out(acc_out), .status_out(status_out));

// ==== rsa_mem_model.sv ====
`timescale 1ns/1ps
module rsa_mem_model (
  input wire logic sys_clk, // System clock
  input wire logic nrst, // Synchronous reset, active low
  input wire logic clk_en, // Clock enable
  input wire logic [3:0] addr, // Byte address from the sequencer
  input wire logic take, // Operation accepted by the core
  input wire logic mem_wr_en, // Write strobe from the core
  input wire logic [7:0] mem_wr_data, // Write byte
  output logic [7:0] mem_rdata // Addressed byte
);
  logic [7:0] mem [16];
  logic [3:0] wr_addr;
  assign mem_rdata = mem[addr];
  // Write goes to the byte addressed at take, not the current one
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      for (int i = 0; i < 16; i++) begin
        mem[i] <= 8'(i * 37 + 5);
      end
    end else if (clk_en && mem_wr_en) begin
      mem[wr_addr] <= mem_wr_data;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (take) begin
      wr_addr <= addr;
    end
  end
endmodule

// ==== rsa_core_tb.sv ====
`timescale 1ns/1ps
module rsa_core_tb;
  import rsa_pkg::*;
  typedef struct packed {
    logic [7:0] acc;
    logic [5:0] st;
    logic [8:0] wr;
    logic sk;
  } rsa_note_t;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic clk_en = 1'b1;
  logic op_valid = 1'b0;
  logic [4:0] op_code = 5'h00;
  logic [7:0] op_imm = 8'h00;
  logic [2:0] op_bit = 3'h0;
  logic [3:0] addr = 4'h0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic op_ready, op_done, skip_next, mem_wr_en;
  logic [7:0] mem_rdata, mem_wr_data, acc_out, reg_rdata;
  logic [5:0] status_out;
  logic rd_seen = 1'b0;
  logic gaps = 1'b0;
  logic [7:0] m_acc = 8'h00;
  logic [5:0] m_st = 6'h00;
  logic [7:0] m_state = 8'h00;
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  rsa_note_t got;
  rsa_note_t opq[$];
  logic [7:0] rdq[$];
  logic [7:0] sub_a [5] = '{8'h00, 8'h80, 8'h7F, 8'h05, 8'h10};
  logic [7:0] sub_b [5] = '{8'h01, 8'h01, 8'hFF, 8'h05, 8'h01};
  rsa_op_t chain_ops [13] = '{RSA_OP_FILL_ONES, RSA_OP_INC_SKIP_ZERO_ACCUM, RSA_OP_INC_SKIP_ZERO,
    RSA_OP_SKIP_ON_ZERO, RSA_OP_SKIP_NONZERO, RSA_OP_INC_SKIP_ZERO, RSA_OP_DEC_SKIP_ZERO_ACCUM,
    RSA_OP_DEC_SKIP_ZERO, RSA_OP_SKIP_BIT_NONZERO, RSA_OP_BIT_SET, RSA_OP_SKIP_BIT_NONZERO,
    RSA_OP_NIBBLE_EXCHANGE_MEM, RSA_OP_ROTATE_RIGHT_MEM};

  rsa_core u_dut (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en), .op_valid(op_valid), .op_code(op_code),
    .op_imm(op_imm), .op_bit(op_bit), .mem_rdata(mem_rdata), .op_ready(op_ready), .op_done(op_done),
    .skip_next(skip_next), .mem_wr_en(mem_wr_en), .mem_wr_data(mem_wr_data), .acc_out(acc_out),
    .status_out(status_out), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  rsa_mem_model u_mem (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en), .addr(addr),
    .take(op_valid && op_ready && clk_en), .mem_wr_en(mem_wr_en), .mem_wr_data(mem_wr_data),
    .mem_rdata(mem_rdata));

  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) clk_en <= gaps ? ($urandom_range(3) != 0) : 1'b1;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
    if (a == RSA_REG_ACC) m_acc = d;
    if (a == RSA_REG_STATUS) m_st = d[5:0];
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic reg_read(input logic [1:0] a, input logic [7:0] exp);
    rdq.push_back(exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic reg_idle();
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge sys_clk);
  endtask

  // Six flags packed as {chained zero, signed, overflow, zero, half, carry}
  function automatic logic [13:0] sub(input logic [7:0] a, input logic [7:0] b, input logic bw, input logic wb);
    logic [8:0] r;
    logic [4:0] h;
    logic ov;
    r = {1'b0, a} - {1'b0, b} - {8'h00, bw};
    h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, bw};
    ov = (a[7] ^ b[7]) & (a[7] ^ r[7]);
    return {r[7:0], (r[7:0] == 8'h00) & (m_st[5] | !wb), r[7] ^ ov, ov, r[7:0] == 8'h00, !h[4], !r[8]};
  endfunction

  task automatic issue(input logic [4:0] c, input logic [7:0] imm, input logic [2:0] b, input logic [3:0] a);
    logic [7:0] m;
    logic [7:0] r;
    logic [1:0] dst;
    logic [5:0] f;
    logic sk;
    op_code <= c;
    op_imm <= imm;
    op_bit <= b;
    addr <= a;
    op_valid <= 1'b1;
    do @(posedge sys_clk); while (!(op_ready && clk_en));
    m = u_mem.mem[a];
    r = 8'h00;
    dst = 2'd0;
    f = m_st;
    sk = 1'b0;
    case (c)
      RSA_OP_ROTL_CARRY_TO_ACCUM: {r, dst, f[0]} = {m[6:0], m_st[0], 2'd1, m[7]};
      RSA_OP_ROTATE_RIGHT_MEM: {r, dst} = {m[0], m[7:1], 2'd2};
      RSA_OP_ROTATE_RIGHT_TO_ACCUM: {r, dst} = {m[0], m[7:1], 2'd1};
      RSA_OP_ROTATE_RIGHT_CARRY_MEM: {r, dst, f[0]} = {m_st[0], m[7:1], 2'd2, m[0]};
      RSA_OP_ROTATE_RIGHT_CARRY_TO_ACCUM: {r, dst, f[0]} = {m_st[0], m[7:1], 2'd1, m[0]};
      RSA_OP_MINUS_BORROW_TO_ACCUM: {r, f, dst} = {sub(m_acc, m, !m_st[0], 1'b1), 2'd1};
      RSA_OP_MINUS_BORROW_IMM: {r, f, dst} = {sub(m_acc, imm, !m_st[0], 1'b1), 2'd1};
      RSA_OP_MINUS_BORROW_TO_MEM: {r, f, dst} = {sub(m_acc, m, !m_st[0], 1'b1), 2'd2};
      RSA_OP_MINUS_TO_ACCUM: {r, f, dst} = {sub(m_acc, m, 1'b0, 1'b0), 2'd1};
      RSA_OP_MINUS_IMM: {r, f, dst} = {sub(m_acc, imm, 1'b0, 1'b0), 2'd1};
      RSA_OP_MINUS_TO_MEM: {r, f, dst} = {sub(m_acc, m, 1'b0, 1'b0), 2'd2};
      RSA_OP_DEC_SKIP_ZERO: {r, dst, sk} = {m - 8'h01, 2'd2, m == 8'h01};
      RSA_OP_DEC_SKIP_ZERO_ACCUM: {r, dst, sk} = {m - 8'h01, 2'd1, m == 8'h01};
      RSA_OP_INC_SKIP_ZERO: {r, dst, sk} = {m + 8'h01, 2'd2, m == 8'hFF};
      RSA_OP_INC_SKIP_ZERO_ACCUM: {r, dst, sk} = {m + 8'h01, 2'd1, m == 8'hFF};
      RSA_OP_FILL_ONES: {r, dst} = {8'hFF, 2'd2};
      RSA_OP_BIT_SET: {r, dst} = {m | (8'h01 << b), 2'd2};
      RSA_OP_SKIP_BIT_NONZERO: sk = m[b];
      RSA_OP_SKIP_NONZERO: {r, dst, sk} = {m, 2'd2, m != 8'h00};
      RSA_OP_SKIP_ON_ZERO: {r, dst, sk} = {m, 2'd2, m == 8'h00};
      RSA_OP_NIBBLE_EXCHANGE_MEM: {r, dst} = {m[3:0], m[7:4], 2'd2};
      RSA_OP_NIBBLE_EXCHANGE_TO_ACCUM: {r, dst} = {m[3:0], m[7:4], 2'd1};
      default: sk = 1'b0;
    endcase
    m_acc = (dst == 2'd1) ? r : m_acc;
    m_st = f;
    // State register after retirement: idle, last skip, last code legal
    m_state = {4'h0, (c <= RSA_OP_NIBBLE_EXCHANGE_TO_ACCUM), sk, 2'b00};
    opq.push_back('{m_acc, f, {dst == 2'd2, (dst == 2'd2) ? r : 8'h00}, sk});
  endtask

  // Bounded drain; also lifts clock gaps before register traffic
  task automatic op_idle();
    op_valid <= 1'b0;
    for (int i = 0; i < 40 && opq.size() > 0; i++) @(posedge sys_clk);
    check(opq.size(), 0);
    gaps = 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

  always @(posedge sys_clk) begin
    if (rd_seen) check(reg_rdata, rdq.pop_front());
    rd_seen <= reg_rd && clk_en && nrst;
    if (op_done && clk_en) begin
      got = opq.pop_front();
      check(acc_out, got.acc);
      check(status_out, got.st);
      check({mem_wr_en, mem_wr_en ? mem_wr_data : 8'h00}, got.wr);
      check(skip_next, got.sk);
    end
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      finish_test();
    end
  end

  initial begin
    void'($urandom(32'h7e5a));
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    reg_read(RSA_REG_ACC, RSA_ACC_RST);
    reg_read(RSA_REG_STATUS, 8'h00);
    reg_write(RSA_REG_ACC, 8'hA5);
    reg_write(2'h3, 8'h5A);
    reg_read(RSA_REG_ACC, 8'hA5);
    reg_read(2'h3, 8'h00);
    reg_write(RSA_REG_STATE, 8'hFF);
    reg_read(RSA_REG_STATE, 8'h00);
    reg_write(RSA_REG_STATUS, 8'h3F);
    reg_read(RSA_REG_STATUS, 8'h3F);
    reg_idle();
    $display("test registers done");
    for (int k = 0; k < 48; k++) begin
      reg_write(RSA_REG_STATUS, {2'b00, k[0], 4'h0, k[0]});
      reg_write(RSA_REG_ACC, 8'($urandom));
      reg_idle();
      issue(5'(k >> 1), 8'($urandom), 3'($urandom), 4'($urandom));
      op_idle();
    end
    $display("test codes done");
    for (int k = 0; k < 40; k++) begin
      reg_write(RSA_REG_STATUS, {2'b00, k[1], 4'h0, k[0]});
      reg_write(RSA_REG_ACC, sub_a[k >> 3]);
      reg_idle();
      issue(k[2] ? RSA_OP_MINUS_BORROW_IMM : RSA_OP_MINUS_IMM, sub_b[k >> 3], 3'h0, 4'h2);
      op_idle();
    end
    $display("test subtract edges done");
    foreach (chain_ops[i]) begin
      issue(chain_ops[i], 8'h00, 3'h7, 4'h1);
      op_idle();
    end
    $display("test skip chain done");
    gaps = 1'b1;
    repeat (300) issue(5'($urandom_range(23)), 8'($urandom), 3'($urandom), 4'($urandom));
    op_idle();
    reg_read(RSA_REG_ACC, m_acc);
    reg_read(RSA_REG_STATUS, {2'b00, m_st});
    reg_read(RSA_REG_STATE, m_state);
    reg_idle();
    repeat (2) @(posedge sys_clk);
    $display("test random done");
    finish_test();
  end
endmodule
